// ### shared/cst_timing_consts.vh
// Timing constants for the camera sync timing block
`ifndef CST_TIMING_CONSTS_VH
`define CST_TIMING_CONSTS_VH

// ***********************************************************
// Clock and time bases
// ***********************************************************
`define CST_SYS_KHZ 200000
`define CST_PIX_KHZ 29500
`define CST_LINE_NS 43050
`define CST_LINE_CYC (`CST_LINE_NS * (`CST_SYS_KHZ / 1000) / 1000)
// Pixel enable is a phase accumulator: add 59, wrap at 400 (29.5 / 200)
`define CST_PIX_INC 9'h03B
`define CST_PIX_MOD 9'h190
`define CST_PIX_HALF 9'h0C8
// Phase window of about 100 pixel clocks, as sys_clk cycles (rounded down)
`define CST_PHASE_PIX 100
`define CST_PHASE_CYC (`CST_PHASE_PIX * `CST_SYS_KHZ / `CST_PIX_KHZ)
// Loss of external sync: two missing lines or two missing full frames
`define CST_HLOSS_CYC (2 * `CST_LINE_CYC)
`define CST_VLOSS_LINES 1592

// ***********************************************************
// Horizontal geometry in pixels
// ***********************************************************
`define CST_H_START 11'h0C8
`define CST_H_ACTIVE 11'h400

// ***********************************************************
// Vertical geometry in lines
// ***********************************************************
`define CST_FULL_TOTAL 10'h31C
`define CST_FULL_START 10'h00E
`define CST_FULL_LINES 10'h300
`define CST_P40_TOTAL 10'h244
`define CST_P40_START 10'h019
`define CST_P40_LINES 10'h21E
`define CST_P42_TOTAL 10'h229
`define CST_P42_START 10'h01B
`define CST_P42_LINES 10'h200
`define CST_P50_TOTAL 10'h1D1
`define CST_P50_START 10'h021
`define CST_P50_LINES 10'h19C
`define CST_P60_TOTAL 10'h183
`define CST_P60_START 10'h027
`define CST_P60_LINES 10'h142
`define CST_P70_TOTAL 10'h14C
`define CST_P70_START 10'h02B
`define CST_P70_LINES 10'h103
`define CST_P80_TOTAL 10'h122
`define CST_P80_START 10'h02E
`define CST_P80_LINES 10'h0D3
`define CST_P90_TOTAL 10'h102
`define CST_P90_START 10'h030
`define CST_P90_LINES 10'h0AF

// ***********************************************************
// Operating modes and vertical restart delay
// ***********************************************************
`define CST_MODE_NORMAL 2'h0
`define CST_MODE_RESTART 2'h1
`define CST_MODE_TRIGGER 2'h2
`define CST_RESTART_LINES 2'h2

`endif

// ### rtl/cst_pin_sync.v
// Two-stage synchroniser with edge pulses for pin inputs
`timescale 1ns/1ps

module cst_pin_sync #(
   parameter WIDTH = 6
) (
   input wire sysClk, // System clock
   input wire resetn, // Asynchronous reset, active low
   input wire [WIDTH-1:0] pinIn, // Raw pin levels
   output wire [WIDTH-1:0] level, // Synchronised levels
   output wire [WIDTH-1:0] fallPulse, // One-cycle pulse on a falling edge
   output wire [WIDTH-1:0] risePulse // One-cycle pulse on a rising edge
);

   reg [WIDTH-1:0] meta_r; // First stage, read by second stage only
   reg [WIDTH-1:0] sync_r; // Second stage
   reg [WIDTH-1:0] prev_r; // Delayed copy for edge finding

   // ***********************************************************
   // Synchroniser chain
   // ***********************************************************
   // Resets high so idle-high sync lines raise no false edge
   always @(posedge sysClk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= {WIDTH{1'b1}};
         sync_r <= {WIDTH{1'b1}};
         prev_r <= {WIDTH{1'b1}};
      end else begin
         meta_r <= pinIn;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign fallPulse = prev_r & ~sync_r;
   assign risePulse = ~prev_r & sync_r;

endmodule // cst_pin_sync

// ### rtl/cst_sync_timing.v
// Line and frame timing with external sync alignment for an RGB camera
`timescale 1ns/1ps
`include "cst_timing_consts.vh"

// What this block does
// - Restart and trigger: output frame 2H later
// - Normal mode uses only falling sync edges
// - Restart any time if horizontal phase holds
// - Active image 1024 pixels by 768 lines
// - Internal line 23.229 kHz, frame 29.18 Hz
// - Frame, line, data valid high, pixel clock
// - Eight bits each of red, green, blue
// - Partial scan at 40 to 90 fps
// - Switch to external sync automatically
// - Select low partial, high full frame
module cst_sync_timing #(
   parameter LINE_CYC = `CST_LINE_CYC, // sys_clk cycles per line
   parameter HLOSS_CYC = `CST_HLOSS_CYC, // Horizontal loss timeout
   parameter VLOSS_LINES = `CST_VLOSS_LINES // Vertical loss timeout in lines
) (
   input wire sysClk, // 200 MHz system clock
   input wire resetn, // Asynchronous reset, active low
   input wire extHsyncN, // External horizontal sync pin, active low
   input wire extVsyncN, // External vertical sync pin, active low
   input wire trigger, // External trigger pin, active high
   input wire fullScanSel, // Pin: high full frame, low partial
   input wire [1:0] opMode, // Pin strap: normal, restart, trigger
   input wire [2:0] rateSel, // Partial rate 0..6 = 40,42,50,60,70,80,90
   input wire [7:0] sensorRed, // Sensor red sample, same clock
   input wire [7:0] sensorGreen, // Sensor green sample, same clock
   input wire [7:0] sensorBlue, // Sensor blue sample, same clock
   output reg pixClk, // Pixel clock out
   output reg frameValid, // Frame valid, active high
   output reg lineValid, // Line valid, active high
   output reg dataValid, // Data valid, one pulse per pixel
   output reg [7:0] redOut, // Red pixel data
   output reg [7:0] greenOut, // Green pixel data
   output reg [7:0] blueOut, // Blue pixel data
   output reg extHsyncLock, // External horizontal sync in use
   output reg extVsyncLock // External vertical sync in use
);

   // ***********************************************************
   // Pin synchronisers
   // ***********************************************************
   wire [5:0] pinLevel; // Synchronised pin levels
   wire [5:0] pinFall; // Falling edge pulses
   wire [5:0] pinRise; // Rising edge pulses

   cst_pin_sync #(.WIDTH(6)) uPinSync (
      .sysClk(sysClk),
      .resetn(resetn),
      .pinIn({opMode, fullScanSel, trigger, extVsyncN, extHsyncN}),
      .level(pinLevel),
      .fallPulse(pinFall),
      .risePulse(pinRise)
   );

   wire hFall = pinFall[0]; // Only the falling edge is a reference
   wire vFall = pinFall[1];
   wire trigRise = pinRise[2]; // Trigger start
   wire fullSel = pinLevel[3];
   wire [1:0] mode = pinLevel[5:4]; // Operating mode
   wire restartMode = (mode == `CST_MODE_RESTART) || (mode == `CST_MODE_TRIGGER);

   // ***********************************************************
   // Vertical geometry lookup
   // ***********************************************************
   reg [9:0] vTotal; // Lines per frame
   reg [9:0] vStart; // First active line
   reg [9:0] vLines; // Active lines

   // Partial rates each have their own vertical timing
   always @* begin
      vTotal = `CST_FULL_TOTAL; // Full frame 768 lines at 29.18 Hz
      vStart = `CST_FULL_START;
      vLines = `CST_FULL_LINES;
      if (!fullSel) begin
         case (rateSel)
            3'h0: begin
               vTotal = `CST_P40_TOTAL; vStart = `CST_P40_START; vLines = `CST_P40_LINES;
            end
            3'h1: begin
               vTotal = `CST_P42_TOTAL; vStart = `CST_P42_START; vLines = `CST_P42_LINES;
            end
            3'h2: begin
               vTotal = `CST_P50_TOTAL; vStart = `CST_P50_START; vLines = `CST_P50_LINES;
            end
            3'h3: begin
               vTotal = `CST_P60_TOTAL; vStart = `CST_P60_START; vLines = `CST_P60_LINES;
            end
            3'h4: begin
               vTotal = `CST_P70_TOTAL; vStart = `CST_P70_START; vLines = `CST_P70_LINES;
            end
            3'h5: begin
               vTotal = `CST_P80_TOTAL; vStart = `CST_P80_START; vLines = `CST_P80_LINES;
            end
            3'h6: begin
               vTotal = `CST_P90_TOTAL; vStart = `CST_P90_START; vLines = `CST_P90_LINES;
            end
            default: begin
               // Unused code falls back to full frame
               vTotal = `CST_FULL_TOTAL; vStart = `CST_FULL_START; vLines = `CST_FULL_LINES;
            end
         endcase
      end
   end

   // ***********************************************************
   // Horizontal counter and sync presence
   // ***********************************************************
   reg [13:0] hCnt_r; // Position in line, sys_clk cycles
   reg [14:0] hLossCnt_r; // Cycles since last external hsync edge
   wire hAlign = hFall && extHsyncLock; // Restart line on external edge
   // While locked the internal end waits about 1.5% longer, so a slow external
   // line inside the allowed tolerance never splits into two short lines
   wire [13:0] lineLast = extHsyncLock ?
                          LINE_CYC[13:0] + {6'h00, LINE_CYC[13:6]} - 14'h0001 :
                          LINE_CYC[13:0] - 14'h0001;
   wire lineEnd = (hCnt_r == lineLast);
   wire lineStart = lineEnd || hAlign; // New line begins next cycle

   // Internal line is 8610 cycles = 23.229 kHz; external edge overrides
   always @(posedge sysClk or negedge resetn) begin
      if (!resetn) begin
         hCnt_r <= 14'h0000;
      end else if (lineStart) begin
         hCnt_r <= 14'h0000;
      end else begin
         hCnt_r <= hCnt_r + 14'h0001;
      end
   end

   // Two edges within the window lock on; silence drops back to internal
   always @(posedge sysClk or negedge resetn) begin
      if (!resetn) begin
         hLossCnt_r <= HLOSS_CYC[14:0];
         extHsyncLock <= 1'b0;
      end else if (hFall) begin
         hLossCnt_r <= 15'h0000;
         extHsyncLock <= (hLossCnt_r < HLOSS_CYC[14:0]);
      end else if (hLossCnt_r < HLOSS_CYC[14:0]) begin
         hLossCnt_r <= hLossCnt_r + 15'h0001;
      end else begin
         extHsyncLock <= 1'b0; // Timed out: internal timing
      end
   end

   // Vertical edge near the line reference counts as in phase
   wire phaseOk = (hCnt_r < `CST_PHASE_CYC) ||
                  (hCnt_r >= LINE_CYC[13:0] - `CST_PHASE_CYC);

   // ***********************************************************
   // Pixel enable and pixel counter
   // ***********************************************************
   reg [8:0] pixAcc_r; // Phase accumulator for 29.5 MHz
   reg [10:0] pxCnt_r; // Pixel index within line
   wire [8:0] pixSum = pixAcc_r + `CST_PIX_INC;
   wire pixEn = (pixSum >= `CST_PIX_MOD) && !lineStart; // One pixel step

   // Accumulator restarts with each line so pixels keep a fixed phase
   always @(posedge sysClk or negedge resetn) begin
      if (!resetn) begin
         pixAcc_r <= 9'h000;
         pxCnt_r <= 11'h000;
         pixClk <= 1'b0;
      end else if (lineStart) begin
         // Restart in the low half so the pixel clock never shows a runt low pulse
         pixAcc_r <= `CST_PIX_HALF;
         pxCnt_r <= 11'h000;
         pixClk <= 1'b0;
      end else begin
         pixAcc_r <= pixEn ? pixSum - `CST_PIX_MOD : pixSum;
         if (pixEn) begin
            pxCnt_r <= pxCnt_r + 11'h001;
         end
         pixClk <= (pixAcc_r < `CST_PIX_HALF); // Pixel clock out
      end
   end

   // ***********************************************************
   // Vertical counter, external alignment and restart
   // ***********************************************************
   reg [9:0] vCnt_r; // Line within frame
   reg frameRun_r; // Frame being output
   reg vAlignPend_r; // Normal mode: restart frame at next line
   reg [1:0] armCnt_r; // Restart: lines left before frame start
   reg [10:0] vLossCnt_r; // Lines since last vertical edge

   // Restart request: vertical edge in phase, or trigger in trigger mode
   wire restartReq = (mode == `CST_MODE_RESTART) ? (vFall && phaseOk) :
                     (mode == `CST_MODE_TRIGGER) ? trigRise : 1'b0;
   wire armFire = lineStart && (armCnt_r == 2'h1); // 2H after the request

   // Frame counter: free run in normal mode, one shot in restart modes
   always @(posedge sysClk or negedge resetn) begin
      if (!resetn) begin
         vCnt_r <= 10'h000;
         frameRun_r <= 1'b1;
         vAlignPend_r <= 1'b0;
         armCnt_r <= 2'h0;
      end else begin
         if (restartReq) begin
            armCnt_r <= `CST_RESTART_LINES;
         end else if (lineStart && armCnt_r != 2'h0) begin
            armCnt_r <= armCnt_r - 2'h1;
         end
         if (!restartMode && vFall) begin
            vAlignPend_r <= 1'b1; // Normal mode uses the falling edge
         end else if (lineStart) begin
            vAlignPend_r <= 1'b0;
         end
         if (lineStart) begin
            if (armFire && !restartReq) begin
               vCnt_r <= 10'h000; // Output vertical sync 2H after request
               frameRun_r <= 1'b1;
            end else if (vAlignPend_r) begin
               vCnt_r <= 10'h000; // Frame locked to external vertical edge
               frameRun_r <= 1'b1;
            end else if (vCnt_r >= vTotal - 10'h001) begin
               vCnt_r <= 10'h000;
               frameRun_r <= !restartMode; // Restart modes wait for next request
            end else begin
               vCnt_r <= vCnt_r + 10'h001;
            end
         end
      end
   end

   // Vertical presence in lines; no edge for two full frames means internal
   always @(posedge sysClk or negedge resetn) begin
      if (!resetn) begin
         vLossCnt_r <= VLOSS_LINES[10:0];
         extVsyncLock <= 1'b0;
      end else if (vFall) begin
         vLossCnt_r <= 11'h000;
         extVsyncLock <= (vLossCnt_r < VLOSS_LINES[10:0]);
      end else if (lineStart && vLossCnt_r < VLOSS_LINES[10:0]) begin
         vLossCnt_r <= vLossCnt_r + 11'h001;
      end else if (vLossCnt_r >= VLOSS_LINES[10:0]) begin
         extVsyncLock <= 1'b0;
      end
   end

   // ***********************************************************
   // Valid strobes and pixel data
   // ***********************************************************
   wire frameAct = frameRun_r && (vCnt_r >= vStart) && (vCnt_r < vStart + vLines);
   wire lineAct = (pxCnt_r >= `CST_H_START) &&
                  (pxCnt_r < `CST_H_START + `CST_H_ACTIVE); // 1024 pixels

   // Strobes active high, data registered per pixel step
   always @(posedge sysClk or negedge resetn) begin
      if (!resetn) begin
         frameValid <= 1'b0;
         lineValid <= 1'b0;
         dataValid <= 1'b0;
         redOut <= 8'h00;
         greenOut <= 8'h00;
         blueOut <= 8'h00;
      end else begin
         frameValid <= frameAct;
         lineValid <= frameAct && lineAct;
         dataValid <= frameAct && lineAct && pixEn;
         if (frameAct && lineAct && pixEn) begin
            redOut <= sensorRed;
            greenOut <= sensorGreen;
            blueOut <= sensorBlue;
         end
      end
   end

endmodule // cst_sync_timing

// ### sim/cst_sync_timing_assertions.sv
// Checker for the camera sync timing block
`timescale 1ns/1ps

module cst_sync_checker #(
   parameter HLOSS_CYC = 17220 // Horizontal loss timeout
) (
   input wire sysClk, // System clock
   input wire resetn, // Reset, active low
   input wire extHsyncN, // Horizontal sync pin
   input wire pixClk, // Pixel clock
   input wire frameValid, // Frame strobe
   input wire lineValid, // Line strobe
   input wire dataValid, // Pixel strobe
   input wire [7:0] redOut, // Red data
   input wire [7:0] greenOut, // Green data
   input wire [7:0] blueOut, // Blue data
   input wire extHsyncLock // External line lock
);
   // ***************
   // Helper counters
   // ***************
   reg [15:0] sinceFall_r; // Cycles since the last raw sync fall
   reg hPrev_r; // Last sampled sync level
   reg [10:0] dvCount_r; // Pixels within the current line
   // Raw pin is sampled here so lock may lag by the synchroniser depth
   always @(posedge sysClk or negedge resetn) begin
      if (!resetn) begin
         sinceFall_r <= 16'h0000;
         hPrev_r <= 1'b1;
         dvCount_r <= 11'h000;
      end else begin
         hPrev_r <= extHsyncN;
         if (hPrev_r && !extHsyncN) begin
            sinceFall_r <= 16'h0000;
         end else if (sinceFall_r != 16'hFFFF) begin
            sinceFall_r <= sinceFall_r + 16'h0001;
         end
         if (!lineValid) begin
            dvCount_r <= 11'h000;
         end else if (dataValid) begin
            dvCount_r <= dvCount_r + 11'h001;
         end
      end
   end
   default clocking cb @(posedge sysClk); endclocking
   default disable iff (!resetn);
   // ***************
   // Properties
   // ***************
   dv_in_line_a: assert property (dataValid |-> lineValid && frameValid)
      else $error("pixel strobe outside line or frame");
   line_in_frame_a: assert property (lineValid |-> frameValid)
      else $error("line strobe outside frame");
   dv_spacing_a: assert property (dataValid |=> !dataValid [*5])
      else $error("pixel strobes closer than the pixel period");
   pix_low_a: assert property ($fell(pixClk) |=> !pixClk [*2])
      else $error("pixel clock low phase too short");
   rgb_hold_a: assert property ($changed({redOut, greenOut, blueOut}) |-> dataValid)
      else $error("pixel data moved without a strobe");
   pix_count_a: assert property (dvCount_r <= 11'h400)
      else $error("more than 1024 pixels in a line");
   lock_cause_a: assert property ($rose(extHsyncLock) |-> sinceFall_r <= 16'h0008)
      else $error("lock rose without a recent sync fall");
   lock_loss_a: assert property (sinceFall_r > HLOSS_CYC + 8 |-> !extHsyncLock)
      else $error("lock held after sync stopped");
   frame_seen_c: cover property ($rose(frameValid));
   lock_seen_c: cover property ($rose(extHsyncLock));
   lock_lost_c: cover property ($fell(extHsyncLock));
endmodule // cst_sync_checker

bind cst_sync_timing cst_sync_checker #(.HLOSS_CYC(HLOSS_CYC)) chk (.sysClk(sysClk),
   .resetn(resetn), .extHsyncN(extHsyncN), .pixClk(pixClk), .frameValid(frameValid),
   .lineValid(lineValid), .dataValid(dataValid), .redOut(redOut), .greenOut(greenOut),
   .blueOut(blueOut), .extHsyncLock(extHsyncLock));

// ### sim/cst_grabber_model.sv
// Frame grabber model driving sync and trigger pins
`timescale 1ns/1ps

module cst_grabber_model #(
   parameter LINE_TICKS = 44 // Line in 160 ns ticks, within one percent
) (
   output reg extHsyncN, // Horizontal sync, active low
   output reg extVsyncN, // Vertical sync, active low
   output reg trigger // Trigger, active high
);
   reg linkClk; // Grabber time base, unrelated to sysClk
   reg hsyncRun; // Line sync enable
   integer tick; // Position within the line
   initial begin
      linkClk = 1'b0;
      extHsyncN = 1'b1;
      extVsyncN = 1'b1;
      trigger = 1'b0;
      hsyncRun = 1'b0;
      tick = 0;
   end
   always #80 linkClk = ~linkClk;
   // Continuous line sync, low for three ticks
   always @(posedge linkClk) begin
      if (!hsyncRun) begin
         extHsyncN <= 1'b1;
         tick <= 0;
      end else begin
         tick <= (tick == LINE_TICKS - 1) ? 0 : tick + 1;
         extHsyncN <= (tick >= 3);
      end
   end
   task run_hsync(input reg on);
      hsyncRun = on;
   endtask
   // Falls together with a line fall, held whole lines
   // Callers start the next vertical pulse one to two lines after the previous one ends
   task send_vsync(input integer lines);
      integer i;
      begin
         @(negedge extHsyncN);
         extVsyncN = 1'b0;
         for (i = 0; i < lines; i = i + 1) @(negedge extHsyncN);
         extVsyncN = 1'b1;
      end
   endtask
   // Pulse longer than 2 us
   task send_trigger;
      begin
         // Leave the time step of the call so a waiting observer sees the edge
         @(posedge linkClk);
         trigger = 1'b1;
         #3000;
         trigger = 1'b0;
      end
   endtask
endmodule // cst_grabber_model

// ### sim/cst_testbench.sv
// Self-checking testbench for the camera sync timing block
`timescale 1ns/1ps

module testbench;
   localparam L = 1400; // Internal line in cycles
   localparam LE = 1408; // External line: 44 ticks of 160 ns
   localparam HL = 3000; // Shortened loss timeout
   reg sysClk = 1'b0;
   reg resetn = 1'b0;
   reg fullScanSel = 1'b1;
   reg [1:0] opMode = 2'h0;
   reg [2:0] rateSel = 3'h6;
   reg [7:0] sensorRed = 8'hA5;
   reg [7:0] sensorGreen = 8'h3C;
   reg [7:0] sensorBlue = 8'hC6;
   wire extHsyncN, extVsyncN, trigger, pixClk, frameValid, lineValid, dataValid;
   wire extHsyncLock, extVsyncLock;
   wire [7:0] redOut, greenOut, blueOut;
   integer badCount = 0;
   integer compares = 0;
   integer cyc = 0;
   integer t0, t1, per, dv;
   always #2.5 sysClk = ~sysClk;
   always @(posedge sysClk) cyc <= cyc + 1;
   cst_grabber_model grab (.extHsyncN(extHsyncN), .extVsyncN(extVsyncN), .trigger(trigger));
   cst_sync_timing #(.LINE_CYC(L), .HLOSS_CYC(HL), .VLOSS_LINES(20)) uut (.sysClk(sysClk),
      .resetn(resetn), .extHsyncN(extHsyncN), .extVsyncN(extVsyncN), .trigger(trigger),
      .fullScanSel(fullScanSel), .opMode(opMode), .rateSel(rateSel), .sensorRed(sensorRed),
      .sensorGreen(sensorGreen), .sensorBlue(sensorBlue), .pixClk(pixClk),
      .frameValid(frameValid), .lineValid(lineValid), .dataValid(dataValid), .redOut(redOut),
      .greenOut(greenOut), .blueOut(blueOut), .extHsyncLock(extHsyncLock),
      .extVsyncLock(extVsyncLock));
   // Range comparison with report
   task rng(input string what, input integer lo, input integer hi, input integer seen);
      begin
         compares = compares + 1;
         if (seen < lo || seen > hi) begin
            badCount = badCount + 1;
            $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, seen);
         end
      end
   endtask
   // Waits for a frame strobe rise under a bound; -1 if none
   task frameRise(input integer lim, output integer at);
      integer n;
      reg p;
      begin
         n = 0;
         at = -1;
         p = frameValid;
         while (at < 0 && n < lim) begin
            @(posedge sysClk);
            #1;
            n = n + 1;
            if (frameValid === 1'b1 && p === 1'b0) at = cyc;
            p = frameValid;
         end
      end
   endtask
   // Measures one line period and its pixels, checking pixel data
   task linePeriod(output integer period, output integer pix);
      integer n, r1;
      reg p;
      begin
         n = 0;
         r1 = -1;
         period = -1;
         pix = 0;
         p = lineValid;
         while (period < 0 && n < 3 * LE) begin
            @(posedge sysClk);
            #1;
            n = n + 1;
            if (lineValid === 1'b1 && p === 1'b0) begin
               if (r1 < 0) r1 = cyc;
               else period = cyc - r1;
            end
            if (dataValid === 1'b1 && r1 >= 0 && period < 0) begin
               pix = pix + 1;
               compares = compares + 1;
               if ({redOut, greenOut, blueOut} !== {sensorRed, sensorGreen, sensorBlue}) begin
                  badCount = badCount + 1;
                  $display("wrong value rgb expected %h seen %h",
                     {sensorRed, sensorGreen, sensorBlue}, {redOut, greenOut, blueOut});
               end
            end
            p = lineValid;
         end
      end
   endtask
   task freeRun;
      begin
         frameRise(16 * L, t1);
         rng("frame start cycle", 14 * L - 2, 14 * L + 4, t1 - t0);
         linePeriod(per, dv);
         rng("internal line period", L, L, per);
         rng("pixels per short line", 5, 7, dv);
         rng("lock without sync", 0, 0, extHsyncLock === 1'b0 ? 0 : 1);
         fullScanSel = 1'b0;
         repeat (8) @(posedge sysClk);
         #1;
         rng("partial scan blanking", 0, 0, frameValid === 1'b0 ? 0 : 1);
         fullScanSel = 1'b1;
         repeat (8) @(posedge sysClk);
         #1;
         rng("full scan active", 1, 1, frameValid === 1'b1 ? 1 : 0);
         $display("test free run done");
      end
   endtask
   task extLock;
      begin
         grab.run_hsync(1'b1);
         repeat (3 * LE) @(posedge sysClk);
         #1;
         rng("lock with sync", 1, 1, extHsyncLock === 1'b1 ? 1 : 0);
         linePeriod(per, dv);
         rng("external line period", LE - 1, LE + 1, per);
         grab.run_hsync(1'b0);
         repeat (HL + LE + 10) @(posedge sysClk);
         #1;
         rng("lock after loss", 0, 0, extHsyncLock === 1'b0 ? 0 : 1);
         grab.run_hsync(1'b1);
         repeat (2 * LE) @(posedge sysClk);
         $display("test external lock done");
      end
   endtask
   // Normal mode: a vertical edge restarts the running frame at the next line
   task normalAlign;
      integer n;
      begin
         fork
            grab.send_vsync(5);
            begin
               @(negedge extVsyncN);
               t0 = cyc;
               n = 0;
               while (frameValid !== 1'b0 && n < 3 * LE) begin
                  @(posedge sysClk);
                  #1;
                  n = n + 1;
               end
               rng("normal frame restart", LE, LE + 8, cyc - t0);
            end
         join
         $display("test normal alignment done");
      end
   endtask
   // Mode 1 takes the vertical sync, mode 2 the trigger
   task delayed(input reg [1:0] mode);
      begin
         @(posedge sysClk);
         #1;
         opMode = mode;
         repeat (LE) @(posedge sysClk);
         fork
            if (mode == 2'h1) grab.send_vsync(6);
            else grab.send_trigger;
            begin
               if (mode == 2'h1) @(negedge extVsyncN);
               else @(posedge trigger);
               t0 = cyc;
               frameRise(20 * LE, t1);
            end
         join
         rng("output frame delay", 15 * LE, 17 * LE, t1 - t0);
         if (mode == 2'h1) rng("vsync lock", 1, 1, extVsyncLock === 1'b1 ? 1 : 0);
         $display("test delayed frame mode %0d done", mode);
      end
   endtask
   task endOfTest;
      begin
         $display("checks %0d mismatches %0d", compares, badCount);
         if (badCount == 0 && compares > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      repeat (8) @(posedge sysClk);
      #1;
      resetn = 1'b1;
      t0 = cyc;
      freeRun;
      extLock;
      normalAlign;
      delayed(2'h1);
      delayed(2'h2);
      endOfTest;
   end
   // Watchdog: the tests need about 95k cycles, the limit is 100k cycles
   initial begin
      #500000;
      badCount = badCount + 1;
      endOfTest;
   end
endmodule // testbench
